//--- design/pmb_delay_timer.sv
// per-channel fault retry and run hold-low timer
`timescale 1ns/1ps
module pmb_delay_timer
  import pmb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // timing inputs
  input wire logic ms_tick,
  input wire logic fault,
  input wire logic [31:0] retry_ms,
  input wire logic [31:0] restart_ms,
  // run control
  output logic run_low
);
  pmb_tmr_state_t state;
  logic [31:0] elapsed;
  wire retry_done = elapsed >= retry_ms;
  wire restart_done = elapsed >= restart_ms;
  wire release_ok = retry_done && restart_done && !fault;

  // run pin held low from fault until both delays pass and fault is gone
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= TMR_RUN;
      elapsed <= 32'h0000_0000;
      run_low <= 1'b0;
    end else begin
      case (state)
        TMR_RUN: begin
          elapsed <= 32'h0000_0000;
          if (fault) begin
            state <= TMR_HOLD;
            run_low <= 1'b1;
          end
        end
        TMR_HOLD: begin
          if (ms_tick && elapsed != MS_MAX)
            elapsed <= elapsed + 32'h0000_0001;
          if (release_ok) begin
            state <= TMR_RUN;
            run_low <= 1'b0;
          end
        end
        default: begin
          state <= TMR_RUN;
          run_low <= 1'b0;
        end
      endcase
    end
  end
endmodule

//--- design/pmb_mfr_bank.sv
// manufacturer command bank: settings, peaks, fault log, delays
`timescale 1ns/1ps
module pmb_mfr_bank
  import pmb_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
)(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // decoded command port from the serial engine
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_data,
  // answer to the command
  output logic rsp_valid,
  output logic rsp_err,
  output logic [15:0] rsp_data,
  // measurements from the converter
  input wire logic meas_valid,
  input wire logic meas_page,
  input wire logic [15:0] meas_iout,
  input wire logic [15:0] meas_vout,
  input wire logic [15:0] meas_vin,
  input wire logic [15:0] meas_ext_raw,
  input wire logic [15:0] meas_int_temp,
  // calibrated readings
  output logic [15:0] ext_temp_cal,
  output logic [15:0] iout_cal,
  // fault log capture
  input wire logic log_push,
  input wire logic [7:0] log_byte,
  // fault inputs and pins
  input wire logic shared_fault_pin_n,
  input wire logic [1:0] chan_fault,
  output logic [1:0] run_low,
  output logic [3:0] pwm_fault_action,
  // addressing and config
  output logic [6:0] dev_addr,
  output logic [13:0] rail_addr,
  output logic [1:0] rail_addr_en,
  output logic [7:0] pwm_cfg,
  output logic mem_mismatch
);
  // working and nonvolatile settings
  logic [7:0] fault_pin_pwm_response [NPAGE];
  logic [15:0] fault_retry_delay [NPAGE];
  logic [15:0] run_hold_low_delay [NPAGE];
  logic [15:0] sense_tempco [NPAGE];
  logic [15:0] ext_temp_slope [NPAGE];
  logic [15:0] ext_temp_addend [NPAGE];
  logic [7:0] multiphase_rail_address [NPAGE];
  logic [7:0] device_bus_address;
  logic [7:0] shared_pwm_config;
  logic [7:0] nv_resp [NPAGE];
  logic [15:0] nv_retry [NPAGE];
  logic [15:0] nv_restart [NPAGE];
  logic [15:0] nv_tempco [NPAGE];
  logic [15:0] nv_slope [NPAGE];
  logic [15:0] nv_addend [NPAGE];
  logic [7:0] nv_rail [NPAGE];
  logic [7:0] nv_dev_addr;
  logic [7:0] nv_pwm_cfg;
  // peaks
  logic [15:0] peak_output_current [NPAGE];
  logic [15:0] peak_output_voltage [NPAGE];
  logic [15:0] peak_external_temp [NPAGE];
  logic [15:0] peak_input_voltage;
  logic [15:0] peak_internal_temp;
  // fault log memories
  logic [7:0] log_ram [LOG_DEPTH];
  logic [7:0] nv_log [LOG_DEPTH];
  logic [LOG_AW:0] log_count;
  logic [LOG_AW:0] nv_count;
  logic [LOG_AW:0] log_rd_ptr;
  // misc state
  logic page;
  logic [7:0] cml_status;
  logic soft_rst;
  logic [31:0] tick_cnt;
  logic ms_tick;
  logic [2:0] fpin_sync;
  logic fpin_low;

  // command decode
  wire wr = cmd_valid && cmd_write;
  wire rd = cmd_valid && !cmd_write;
  wire wr_resp = wr && cmd_code == CMD_FAULT_RESP;
  wire wr_retry = wr && cmd_code == CMD_RETRY;
  wire wr_restart = wr && cmd_code == CMD_RESTART;
  wire wr_dev = wr && cmd_code == CMD_DEV_ADDR;
  wire wr_pwm = wr && cmd_code == CMD_PWM_CFG;
  wire wr_tempco = wr && cmd_code == CMD_TEMPCO;
  wire wr_slope = wr && cmd_code == CMD_SLOPE;
  wire wr_addend = wr && cmd_code == CMD_ADDEND;
  wire wr_rail = wr && cmd_code == CMD_RAIL;
  wire wr_page = wr && cmd_code == CMD_PAGE;
  wire wr_cml = wr && cmd_code == CMD_CML;
  wire do_peak_clr = wr && cmd_code == CMD_PEAK_CLR;
  wire do_log_save = wr && cmd_code == CMD_LOG_SAVE;
  wire do_log_erase = wr && cmd_code == CMD_LOG_ERASE;
  wire do_compare = wr && cmd_code == CMD_COMPARE;
  wire do_full_rst = wr && cmd_code == CMD_FULL_RST;
  wire do_store = wr && cmd_code == CMD_STORE_ALL;
  wire do_restore = wr && cmd_code == CMD_RESTORE_ALL;
  wire rd_log = rd && cmd_code == CMD_LOG_READ;
  wire wr_known = wr_resp || wr_retry || wr_restart || wr_dev || wr_pwm
    || wr_tempco || wr_slope || wr_addend || wr_rail || wr_page || wr_cml
    || do_peak_clr || do_log_save || do_log_erase || do_compare
    || do_full_rst || do_store || do_restore;
  wire wr_bad = wr && !wr_known;
  wire clear_all = reset || soft_rst;

  // working memory versus nonvolatile copy
  wire page_diff0 = fault_pin_pwm_response[0] != nv_resp[0]
    || fault_retry_delay[0] != nv_retry[0]
    || run_hold_low_delay[0] != nv_restart[0]
    || sense_tempco[0] != nv_tempco[0] || ext_temp_slope[0] != nv_slope[0]
    || ext_temp_addend[0] != nv_addend[0]
    || multiphase_rail_address[0] != nv_rail[0];
  wire page_diff1 = fault_pin_pwm_response[1] != nv_resp[1]
    || fault_retry_delay[1] != nv_retry[1]
    || run_hold_low_delay[1] != nv_restart[1]
    || sense_tempco[1] != nv_tempco[1] || ext_temp_slope[1] != nv_slope[1]
    || ext_temp_addend[1] != nv_addend[1]
    || multiphase_rail_address[1] != nv_rail[1];
  wire any_diff = page_diff0 || page_diff1 || device_bus_address != nv_dev_addr
    || shared_pwm_config != nv_pwm_cfg;

  // calibration arithmetic; scaling is a power of two, so tempco is ~5% coarse
  wire signed [32:0] slope_prod = $signed(meas_ext_raw)
    * $signed({1'b0, ext_temp_slope[meas_page]});
  wire signed [15:0] addend_val = {{5{ext_temp_addend[meas_page][10]}},
    ext_temp_addend[meas_page][10:0]};
  wire [15:0] next_ext = 16'(slope_prod >>> SLOPE_FRAC) + addend_val;
  wire signed [15:0] temp_delta = $signed(meas_int_temp) - TEMP_REF_C;
  wire signed [48:0] tc_prod = $signed(meas_iout)
    * $signed({1'b0, sense_tempco[meas_page]}) * temp_delta;
  wire [15:0] next_iout = meas_iout + 16'(tc_prod >>> TEMPCO_FRAC);

  // status views
  wire [7:0] general_status = {3'h0, mem_mismatch, fpin_low, 1'b0, run_low};
  wire [15:0] pad_state = {12'h000, fpin_low, 1'b0, run_low};
  wire [7:0] log_out = (log_rd_ptr == '0) ? {3'h0, nv_count}
    : nv_log[LOG_AW'(log_rd_ptr - 1'b1)];

  // read multiplexer
  logic [15:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (cmd_code)
      CMD_PAGE: rd_val = {15'h0000, page};
      CMD_CML: rd_val = {8'h00, cml_status};
      CMD_REVISION: rd_val = {8'h00, REVISION_VALUE};
      CMD_FAULT_RESP: rd_val = {8'h00, fault_pin_pwm_response[page]};
      CMD_OT_RESP: rd_val = {8'h00, OT_RESP_VALUE};
      CMD_PK_IOUT: rd_val = peak_output_current[page];
      CMD_RETRY: rd_val = fault_retry_delay[page];
      CMD_RESTART: rd_val = run_hold_low_delay[page];
      CMD_PK_VOUT: rd_val = peak_output_voltage[page];
      CMD_PK_VIN: rd_val = peak_input_voltage;
      CMD_PK_EXT: rd_val = peak_external_temp[page];
      CMD_PADS: rd_val = pad_state;
      CMD_DEV_ADDR: rd_val = {8'h00, device_bus_address};
      CMD_LOG_READ: rd_val = {8'h00, log_out};
      CMD_STATUS: rd_val = {8'h00, general_status};
      CMD_PK_INT: rd_val = peak_internal_temp;
      CMD_PWM_CFG: rd_val = {8'h00, shared_pwm_config};
      CMD_TEMPCO: rd_val = sense_tempco[page];
      CMD_SLOPE: rd_val = ext_temp_slope[page];
      CMD_ADDEND: rd_val = ext_temp_addend[page];
      CMD_RAIL: rd_val = {8'h00, multiphase_rail_address[page]};
      default: begin
        rd_val = 16'h0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // answer registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      rsp_data <= 16'h0000;
    end else begin
      rsp_valid <= cmd_valid;
      rsp_err <= cmd_valid && (cmd_write ? wr_bad : !rd_ok);
      rsp_data <= rd ? rd_val : 16'h0000;
    end
  end

  // full reset pulse one cycle after the command
  always_ff @(posedge ref_clk) begin
    if (reset)
      soft_rst <= 1'b0;
    else
      soft_rst <= do_full_rst;
  end

  // page select and comm status; a new error beats a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (clear_all) begin
      page <= 1'b0;
      cml_status <= 8'h00;
    end else begin
      if (wr_page)
        page <= cmd_data[0];
      if (wr_cml)
        cml_status <= cml_status & ~cmd_data[7:0];
      if (wr_bad || (rd && !rd_ok))
        cml_status[CML_BAD_CMD] <= 1'b1;
      if (do_compare && any_diff)
        cml_status[CML_MEM] <= 1'b1;
    end
  end

  // settings: written by host, stored and reloaded as a set
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int p = 0; p < NPAGE; p++) begin
        fault_pin_pwm_response[p] <= DEF_FAULT_RESP;
        fault_retry_delay[p] <= DEF_RETRY;
        run_hold_low_delay[p] <= DEF_RESTART;
        sense_tempco[p] <= DEF_TEMPCO;
        ext_temp_slope[p] <= DEF_SLOPE;
        ext_temp_addend[p] <= DEF_ADDEND;
        multiphase_rail_address[p] <= DEF_RAIL;
        nv_resp[p] <= DEF_FAULT_RESP;
        nv_retry[p] <= DEF_RETRY;
        nv_restart[p] <= DEF_RESTART;
        nv_tempco[p] <= DEF_TEMPCO;
        nv_slope[p] <= DEF_SLOPE;
        nv_addend[p] <= DEF_ADDEND;
        nv_rail[p] <= DEF_RAIL;
      end
      device_bus_address <= DEF_DEV_ADDR;
      shared_pwm_config <= DEF_PWM_CFG;
      nv_dev_addr <= DEF_DEV_ADDR;
      nv_pwm_cfg <= DEF_PWM_CFG;
    end else if (do_restore || soft_rst) begin
      for (int p = 0; p < NPAGE; p++) begin
        fault_pin_pwm_response[p] <= nv_resp[p];
        fault_retry_delay[p] <= nv_retry[p];
        run_hold_low_delay[p] <= nv_restart[p];
        sense_tempco[p] <= nv_tempco[p];
        ext_temp_slope[p] <= nv_slope[p];
        ext_temp_addend[p] <= nv_addend[p];
        multiphase_rail_address[p] <= nv_rail[p];
      end
      device_bus_address <= nv_dev_addr;
      shared_pwm_config <= nv_pwm_cfg;
    end else if (do_store) begin
      for (int p = 0; p < NPAGE; p++) begin
        nv_resp[p] <= fault_pin_pwm_response[p];
        nv_retry[p] <= fault_retry_delay[p];
        nv_restart[p] <= run_hold_low_delay[p];
        nv_tempco[p] <= sense_tempco[p];
        nv_slope[p] <= ext_temp_slope[p];
        nv_addend[p] <= ext_temp_addend[p];
        nv_rail[p] <= multiphase_rail_address[p];
      end
      nv_dev_addr <= device_bus_address;
      nv_pwm_cfg <= shared_pwm_config;
    end else begin
      if (wr_resp)
        fault_pin_pwm_response[page] <= cmd_data[7:0];
      if (wr_retry)
        fault_retry_delay[page] <= cmd_data;
      if (wr_restart)
        run_hold_low_delay[page] <= cmd_data;
      if (wr_tempco)
        sense_tempco[page] <= cmd_data;
      if (wr_slope)
        ext_temp_slope[page] <= cmd_data;
      if (wr_addend)
        ext_temp_addend[page] <= cmd_data;
      if (wr_rail)
        multiphase_rail_address[page] <= cmd_data[7:0];
      if (wr_dev)
        device_bus_address <= {1'b0, cmd_data[6:0]};
      if (wr_pwm)
        shared_pwm_config <= cmd_data[7:0];
    end
  end

  // mismatch flag latched by the compare command, dropped on full reset
  always_ff @(posedge ref_clk) begin
    if (clear_all)
      mem_mismatch <= 1'b0;
    else if (do_compare)
      mem_mismatch <= any_diff;
  end

  // peak tracking; clear command and resets win over a sample
  always_ff @(posedge ref_clk) begin
    if (clear_all || do_peak_clr) begin
      for (int p = 0; p < NPAGE; p++) begin
        peak_output_current[p] <= PEAK_RESET;
        peak_output_voltage[p] <= PEAK_RESET;
        peak_external_temp[p] <= PEAK_RESET;
      end
      peak_input_voltage <= PEAK_RESET;
      peak_internal_temp <= PEAK_RESET;
    end else if (meas_valid) begin
      if (next_iout > peak_output_current[meas_page])
        peak_output_current[meas_page] <= next_iout;
      if (meas_vout > peak_output_voltage[meas_page])
        peak_output_voltage[meas_page] <= meas_vout;
      if (next_ext > peak_external_temp[meas_page])
        peak_external_temp[meas_page] <= next_ext;
      if (meas_vin > peak_input_voltage)
        peak_input_voltage <= meas_vin;
      if (meas_int_temp > peak_internal_temp)
        peak_internal_temp <= meas_int_temp;
    end
  end

  // calibrated reading outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ext_temp_cal <= 16'h0000;
      iout_cal <= 16'h0000;
    end else if (meas_valid) begin
      ext_temp_cal <= next_ext;
      iout_cal <= next_iout;
    end
  end

  // working fault log; stops filling when full so early entries survive
  always_ff @(posedge ref_clk) begin
    if (clear_all) begin
      log_count <= '0;
    end else if (log_push && log_count != (LOG_AW + 1)'(LOG_DEPTH)) begin
      log_ram[LOG_AW'(log_count)] <= log_byte;
      log_count <= log_count + 1'b1;
    end
  end

  // nonvolatile log: save, erase and block readout pointer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      nv_count <= '0;
      log_rd_ptr <= '0;
    end else begin
      if (do_log_save) begin
        for (int i = 0; i < LOG_DEPTH; i++)
          nv_log[i] <= log_ram[i];
        nv_count <= log_count;
      end else if (do_log_erase) begin
        nv_count <= '0;
      end
      if (rd_log && log_rd_ptr != nv_count)
        log_rd_ptr <= log_rd_ptr + 1'b1;
      else if (cmd_valid)
        log_rd_ptr <= '0;
    end
  end

  // millisecond tick for the delay timers
  always_ff @(posedge ref_clk) begin
    if (reset || tick_cnt == 32'(CYC_PER_MS_P - 1)) begin
      tick_cnt <= 32'h0000_0000;
      ms_tick <= !reset;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      ms_tick <= 1'b0;
    end
  end

  // shared fault pin: three stages, counted once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fpin_sync <= 3'h7;
      fpin_low <= 1'b0;
    end else begin
      fpin_sync <= {fpin_sync[1:0], shared_fault_pin_n};
      if (fpin_sync[1] == fpin_sync[2])
        fpin_low <= !fpin_sync[2];
    end
  end

  // pin-driven outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pwm_fault_action <= 4'h0;
      dev_addr <= DEF_DEV_ADDR[6:0];
      rail_addr <= 14'h0000;
      rail_addr_en <= 2'b00;
      pwm_cfg <= DEF_PWM_CFG;
    end else begin
      for (int p = 0; p < NPAGE; p++) begin
        pwm_fault_action[2*p +: 2] <= fpin_low
          ? fault_pin_pwm_response[p][RESP_ACT_HI:RESP_ACT_LO] : 2'b00;
        rail_addr[7*p +: 7] <= multiphase_rail_address[p][6:0];
        rail_addr_en[p] <= !multiphase_rail_address[p][RAIL_OFF_BIT];
      end
      dev_addr <= device_bus_address[6:0];
      pwm_cfg <= shared_pwm_config;
    end
  end

  // one retry and hold-low timer per channel
  for (genvar g = 0; g < NPAGE; g++) begin : g_tmr
    pmb_delay_timer u_tmr (
      .ref_clk(ref_clk),
      .reset(clear_all),
      .ms_tick(ms_tick),
      .fault(chan_fault[g]),
      .retry_ms(l11_to_ms(fault_retry_delay[g])),
      .restart_ms(l11_to_ms(run_hold_low_delay[g])),
      .run_low(run_low[g])
    );
  end
endmodule

//--- design/pmb_pkg.sv
// constants, codes and helpers for the manufacturer command bank
package pmb_pkg;
  // command codes
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_STORE_ALL = 8'h15;
  localparam logic [7:0] CMD_RESTORE_ALL = 8'h16;
  localparam logic [7:0] CMD_CML = 8'h7E;
  localparam logic [7:0] CMD_REVISION = 8'h98;
  localparam logic [7:0] CMD_FAULT_RESP = 8'hD5;
  localparam logic [7:0] CMD_OT_RESP = 8'hD6;
  localparam logic [7:0] CMD_PK_IOUT = 8'hD7;
  localparam logic [7:0] CMD_RETRY = 8'hDB;
  localparam logic [7:0] CMD_RESTART = 8'hDC;
  localparam logic [7:0] CMD_PK_VOUT = 8'hDD;
  localparam logic [7:0] CMD_PK_VIN = 8'hDE;
  localparam logic [7:0] CMD_PK_EXT = 8'hDF;
  localparam logic [7:0] CMD_PEAK_CLR = 8'hE3;
  localparam logic [7:0] CMD_PADS = 8'hE5;
  localparam logic [7:0] CMD_DEV_ADDR = 8'hE6;
  localparam logic [7:0] CMD_LOG_SAVE = 8'hEA;
  localparam logic [7:0] CMD_LOG_ERASE = 8'hEC;
  localparam logic [7:0] CMD_LOG_READ = 8'hEE;
  localparam logic [7:0] CMD_STATUS = 8'hEF;
  localparam logic [7:0] CMD_COMPARE = 8'hF0;
  localparam logic [7:0] CMD_PK_INT = 8'hF4;
  localparam logic [7:0] CMD_PWM_CFG = 8'hF5;
  localparam logic [7:0] CMD_TEMPCO = 8'hF6;
  localparam logic [7:0] CMD_SLOPE = 8'hF8;
  localparam logic [7:0] CMD_ADDEND = 8'hF9;
  localparam logic [7:0] CMD_RAIL = 8'hFA;
  localparam logic [7:0] CMD_FULL_RST = 8'hFD;
  // reset and fixed values
  localparam logic [7:0] DEF_FAULT_RESP = 8'hC0;
  localparam logic [7:0] OT_RESP_VALUE = 8'hC0;
  localparam logic [15:0] DEF_RETRY = 16'hFABC;
  localparam logic [15:0] DEF_RESTART = 16'hFBE8;
  localparam logic [7:0] DEF_DEV_ADDR = 8'h4F;
  localparam logic [7:0] DEF_RAIL = 8'h80;
  localparam logic [7:0] DEF_PWM_CFG = 8'h14;
  localparam logic [15:0] DEF_TEMPCO = 16'h0F3C;
  localparam logic [15:0] DEF_SLOPE = 16'h4000;
  localparam logic [15:0] DEF_ADDEND = 16'h8000;
  localparam logic [7:0] REVISION_VALUE = 8'h22;
  localparam logic [15:0] PEAK_RESET = 16'h0000;
  // field positions
  localparam int RESP_ACT_HI = 7;
  localparam int RESP_ACT_LO = 6;
  localparam int RAIL_OFF_BIT = 7;
  localparam int CML_BAD_CMD = 7;
  localparam int CML_BAD_DATA = 6;
  localparam int CML_MEM = 4;
  localparam int ST_MISMATCH = 4;
  localparam int ST_FAULT_PIN = 3;
  localparam int ST_RUN_HI = 1;
  localparam int ST_RUN_LO = 0;
  // arithmetic scaling
  localparam int SLOPE_FRAC = 14;
  localparam int TEMPCO_FRAC = 20;
  localparam logic signed [15:0] TEMP_REF_C = 16'sh001B;
  // sizes
  localparam int NPAGE = 2;
  localparam int LOG_DEPTH = 16;
  localparam int LOG_AW = 4;
  // timing: one millisecond tick from the 200 MHz clock
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_MS = 1;
  localparam int CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;
  localparam logic [31:0] MS_MAX = 32'hFFFF_FFFF;

  typedef enum logic {TMR_RUN, TMR_HOLD} pmb_tmr_state_t;

  // linear-11 millisecond value to a whole count of ms
  function automatic logic [31:0] l11_to_ms(input logic [15:0] v);
    logic signed [4:0] e;
    logic [31:0] m;
    e = $signed(v[15:11]);
    m = {21'h000000, v[10:0]};
    if (v[10])
      l11_to_ms = 32'h0000_0000;
    else if (e < 0)
      l11_to_ms = m >> (-e);
    else
      l11_to_ms = m << e;
  endfunction
endpackage

//--- testbench/pmb_bank_monitor.sv
// port assertions for the manufacturer command bank
`timescale 1ns/1ps
module pmb_bank_monitor
  import pmb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [15:0] rsp_data,
  // pins
  input wire logic shared_fault_pin_n,
  input wire logic [1:0] chan_fault,
  input wire logic [1:0] run_low,
  input wire logic [3:0] pwm_fault_action
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // read and write strobes
  wire rd = cmd_valid && !cmd_write;
  wire wr = cmd_valid && cmd_write;
  rsp_next_a: assert property (cmd_valid |=> rsp_valid) else $error("no answer");
  rsp_idle_a: assert property (!cmd_valid |=> !rsp_valid) else $error("stray answer");
  ro_refuse_a: assert property (wr && cmd_code == CMD_OT_RESP |=> rsp_err)
    else $error("write to read-only code accepted");
  ot_value_a: assert property (rd && cmd_code == CMD_OT_RESP |=> rsp_data == 16'h00C0)
    else $error("overtemp response wrong");
  rev_value_a: assert property (rd && cmd_code == CMD_REVISION |=> rsp_data == 16'h0022)
    else $error("revision wrong");
  clr_ok_a: assert property (wr && cmd_code == CMD_PEAK_CLR |=> !rsp_err)
    else $error("peak clear refused");
  // restart delay is many ms, so eight cycles is a safe lower bound
  run_hold_a: assert property ($rose(chan_fault[0]) |=> run_low[0] [*8])
    else $error("run not held low");
  run_keep_a: assert property (run_low[0] && chan_fault[0] |=> run_low[0])
    else $error("run released during fault");
  pin_quiet_a: assert property (shared_fault_pin_n [*6] |-> pwm_fault_action == 4'h0)
    else $error("fault action without pin");
  cover property (rd && cmd_code == CMD_LOG_READ);
  cover property ($fell(run_low[0]));
  cover property (!shared_fault_pin_n [*6]);
endmodule

bind pmb_mfr_bank pmb_bank_monitor u_mon (.ref_clk, .reset, .cmd_valid, .cmd_write,
  .cmd_code, .rsp_valid, .rsp_err, .rsp_data, .shared_fault_pin_n, .chan_fault,
  .run_low, .pwm_fault_action);

//--- testbench/pmb_host_model.sv
// host side model issuing decoded commands
`timescale 1ns/1ps
module pmb_host_model (
  // clock
  input wire logic ref_clk,
  // request
  output logic cmd_valid = 1'b0,
  output logic cmd_write = 1'b0,
  output logic [7:0] cmd_code = 8'h00,
  output logic [15:0] cmd_data = 16'h0000,
  // answer
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [15:0] rsp_data
);
  // released code and data are inverted so a stale value never looks valid
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] rd, output logic err);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_data = d;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    cmd_code = ~c;
    cmd_data = ~d;
    rd = rsp_data;
    err = rsp_valid ? rsp_err : 1'b1;
  endtask
endmodule

//--- testbench/tb.sv
// self-checking bench for the manufacturer command bank
`timescale 1ns/1ps
module tb;
  import pmb_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, meas_valid = 1'b0, log_push = 1'b0, pin_n = 1'b1;
  logic cmd_valid, cmd_write, rsp_valid, rsp_err, er, mism;
  logic [1:0] chan_fault = 2'b00, run_low;
  logic [3:0] pfa;
  logic [7:0] cmd_code, log_byte = 8'h00;
  logic [15:0] cmd_data, rsp_data, rd, mv = 16'h0000, etc, ioc;
  logic [6:0] da;
  logic [13:0] ra;
  logic [1:0] rae;
  logic [7:0] pc;
  int error_cnt = 0, num_checks = 0, cyc = 0, n;
  always #2.5 ref_clk = ~ref_clk;
  pmb_host_model host (.ref_clk, .cmd_valid, .cmd_write, .cmd_code, .cmd_data,
    .rsp_valid, .rsp_err, .rsp_data);
  // ms tick shortened to 4 cycles so 500 ms lasts 2000 cycles
  pmb_mfr_bank #(.CYC_PER_MS_P(4)) DUT (.ref_clk, .reset, .cmd_valid, .cmd_write,
    .cmd_code, .cmd_data, .rsp_valid, .rsp_err, .rsp_data, .meas_valid,
    .meas_page(1'b0), .meas_iout(mv), .meas_vout(mv + 16'h0001),
    .meas_vin(mv + 16'h0002), .meas_ext_raw(mv + 16'h0003),
    .meas_int_temp(mv + 16'h0004), .ext_temp_cal(etc), .iout_cal(ioc), .log_push, .log_byte,
    .shared_fault_pin_n(pin_n), .chan_fault, .run_low, .pwm_fault_action(pfa),
    .dev_addr(da), .rail_addr(ra), .rail_addr_en(rae), .pwm_cfg(pc), .mem_mismatch(mism));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // read a code and compare
  task automatic rc(input logic [7:0] c, input logic [15:0] e);
    host.xfer(1'b0, c, 16'h0000, rd, er);
    check(rd, e);
  endtask
  task automatic meas(input logic [15:0] v);
    @(negedge ref_clk);
    mv = v;
    meas_valid = 1'b1;
    @(negedge ref_clk);
    meas_valid = 1'b0;
  endtask
  task automatic t_refuse();
    host.xfer(1'b1, CMD_OT_RESP, 16'h0055, rd, er);
    check({15'h0000, er}, 16'h0001);
    rc(CMD_OT_RESP, 16'h00C0);
    rc(CMD_CML, 16'h0080);
  endtask
  // a lower sample must not displace the held maximum
  task automatic t_peaks();
    logic [7:0] pk [5] = '{CMD_PK_IOUT, CMD_PK_VOUT, CMD_PK_VIN, CMD_PK_EXT, CMD_PK_INT};
    // iout peak carries the tempco lift: 291 + 290 at 268 degrees over reference
    logic [15:0] ex [5] = '{16'h0245, 16'h0124, 16'h0125, 16'h0126, 16'h0127};
    meas(16'h0123);
    meas(16'h0100);
    check(etc, 16'h0103);
    check(ioc, 16'h01DD);
    for (int i = 0; i < 5; i++)
      rc(pk[i], ex[i]);
    host.xfer(1'b1, CMD_PEAK_CLR, 16'h0000, rd, er);
    for (int i = 0; i < 5; i++)
      rc(pk[i], 16'h0000);
  endtask
  task automatic t_log();
    for (int i = 0; i < 2; i++) begin
      @(negedge ref_clk);
      log_push = 1'b1;
      log_byte = 8'hA5 ^ 8'(i * 8'h99);
      @(negedge ref_clk);
      log_push = 1'b0;
    end
    // readout shows the saved copy, so save first
    host.xfer(1'b1, CMD_LOG_SAVE, 16'h0000, rd, er);
    check({15'h0000, er}, 16'h0000);
    rc(CMD_LOG_READ, 16'h0002);
    rc(CMD_LOG_READ, 16'h00A5);
    rc(CMD_LOG_READ, 16'h003C);
    host.xfer(1'b1, CMD_LOG_ERASE, 16'h0000, rd, er);
    check({15'h0000, er}, 16'h0000);
    rc(CMD_LOG_READ, 16'h0000);
  endtask
  task automatic t_timer();
    @(negedge ref_clk);
    chan_fault = 2'b01;
    @(negedge ref_clk);
    chan_fault = 2'b00;
    rc(CMD_STATUS, 16'h0001);
    n = 0;
    while (run_low[0] && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    check({15'h0000, n >= 1985 && n <= 2015}, 16'h0001);
  endtask
  task automatic t_pin();
    pin_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    check({12'h000, pfa}, 16'h000F);
    rc(CMD_STATUS, 16'h0008);
    pin_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    check({12'h000, pfa}, 16'h0000);
  endtask
  task automatic t_nvm();
    host.xfer(1'b1, CMD_PWM_CFG, 16'h0033, rd, er);
    host.xfer(1'b1, CMD_COMPARE, 16'h0000, rd, er);
    check({15'h0000, mism}, 16'h0001);
    meas(16'h0200);
    host.xfer(1'b1, CMD_FULL_RST, 16'h0000, rd, er);
    rc(CMD_PWM_CFG, 16'h0014);
    check({15'h0000, mism}, 16'h0000);
    rc(CMD_PK_IOUT, 16'h0000);
    host.xfer(1'b1, CMD_PWM_CFG, 16'h0033, rd, er);
    host.xfer(1'b1, CMD_STORE_ALL, 16'h0000, rd, er);
    host.xfer(1'b1, CMD_COMPARE, 16'h0000, rd, er);
    check({15'h0000, mism}, 16'h0000);
    host.xfer(1'b1, CMD_PWM_CFG, 16'h0021, rd, er);
    host.xfer(1'b1, CMD_RESTORE_ALL, 16'h0000, rd, er);
    rc(CMD_PWM_CFG, 16'h0033);
    check({8'h00, pc}, 16'h0033);
  endtask
  // cut a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    rc(CMD_FAULT_RESP, 16'h00C0);
    rc(CMD_RETRY, 16'hFABC);
    rc(CMD_RESTART, 16'hFBE8);
    rc(CMD_DEV_ADDR, 16'h004F);
    rc(CMD_RAIL, 16'h0080);
    rc(CMD_SLOPE, 16'h4000);
    rc(CMD_ADDEND, 16'h8000);
    rc(CMD_TEMPCO, 16'h0F3C);
    rc(CMD_REVISION, 16'h0022);
    rc(CMD_PK_IOUT, 16'h0000);
    check({9'h000, da}, 16'h004F);
    check({8'h00, pc}, 16'h0014);
    check({2'b00, ra}, 16'h0000);
    check({14'h0000, rae}, 16'h0000);
    t_refuse();
    t_peaks();
    t_log();
    t_timer();
    t_pin();
    t_nvm();
    conclude();
  end
endmodule
